// ==== pkg/irq_map.svh ====
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

// register byte offsets
`define OFS_DATA        8'h00
`define OFS_IER         8'h18
`define OFS_ISR         8'h1C
`define OFS_TRSR        8'h20
`define OFS_CTRL        8'h28

// interrupt status / enable bit positions
`define ISR_CONV        10
`define ISR_RTO         9
`define ISR_INIT        8
`define ISR_CD          7
`define ISR_BGT         6
`define ISR_TMR2        5
`define ISR_TMR1        4
`define ISR_TMR0        3
`define ISR_TERR        2
`define ISR_TBE         1
`define ISR_RDA         0
`define IER_MASK        32'h000007FF
`define ISR_W1C_MASK    32'h000005F8
`define ISR_RESET       32'h00000002

// transfer status bit positions
`define TR_TX_ACT       31
`define TR_TX_LIMIT     30
`define TR_TX_RETRY     29
`define TR_TX_PTR_HI    25
`define TR_TX_PTR_LO    24
`define TR_RX_ACT       23
`define TR_RX_LIMIT     22
`define TR_RX_PTR_HI    17
`define TR_RX_PTR_LO    16
`define TR_CD_INS       12
`define TR_CD_REM       11
`define TR_TX_FULL      10
`define TR_TX_EMPTY     9
`define TR_TX_OVER      8
`define TR_RX_BREAK     6
`define TR_RX_FRAME     5
`define TR_RX_PARITY    4
`define TR_RX_FULL      2
`define TR_RX_EMPTY     1
`define TR_RX_OVER      0
`define TR_W1C_MASK     32'h60401971
`define TR_ERR_MASK     32'h40400171
`define TR_RESET        32'h00000202

// control register bit positions
`define CT_ACT          0
`define CT_DEACT        1
`define CT_WARM         2
`define CT_RETRY_EN     3
`define CT_BGT_EN       4
`define CT_LEV_HI       7
`define CT_LEV_LO       6
`define CT_MASK         32'h000000DF
`define CT_CFG_MASK     8'hD8

// convention bytes and buffer depth
`define TS_DIRECT       8'h3B
`define TS_INVERSE      8'h3F
`define BUF_DEPTH       3'h4

`endif

// ==== pkg/irq_pkg.sv ====
package irq_pkg;
  // one register word
  typedef logic [31:0] word_t;
  // buffer occupancy, 0 to 4
  typedef logic [2:0]  occ_t;
endpackage

// ==== pkg/irq_if.sv ====
`timescale 1ns/10ps
// set/clear/state of a bank of sticky flags
interface flag_if;
  import irq_pkg::*;
  word_t set;
  word_t clr;
  word_t q;
  modport owner (output set, output clr, input q);
  modport bank  (input set, input clr, output q);
endinterface

// occupancy tracking of a four byte buffer
interface occ_if;
  import irq_pkg::*;
  logic push;
  logic pop;
  logic over;
  logic drain;
  occ_t count;
  modport owner (output push, output pop, input over, input drain, input count);
  modport cnt   (input push, input pop, output over, output drain, output count);
endinterface

// ==== verilog/sticky_flags.sv ====
`timescale 1ns/10ps
`include "irq_map.svh"
module sticky_flags
  import irq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // flag bank
  flag_if.bank     bus
);
  word_t q_q; // held flags

  // set beats a clear arriving in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      q_q <= 32'h00000000;
    else
      q_q <= (q_q & ~bus.clr) | bus.set;
  end

  assign bus.q = q_q;
endmodule

// ==== verilog/occupancy_counter.sv ====
`timescale 1ns/10ps
`include "irq_map.svh"
module occupancy_counter
  import irq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // push/pop side
  occ_if.cnt       port
);
  occ_t count_q; // bytes held
  occ_t count_d; // next count
  logic push_ok; // push accepted
  logic pop_ok;  // pop accepted

  // a push into a full buffer is refused and reported
  always_comb
  begin
    push_ok    = port.push && (count_q != `BUF_DEPTH);
    pop_ok     = port.pop && (count_q != 3'h0);
    port.over  = port.push && (count_q == `BUF_DEPTH);
    port.drain = pop_ok && !push_ok && (count_q == 3'h1);
    count_d    = count_q;
    if (push_ok && !pop_ok)
      count_d = count_q + 3'h1;
    else if (pop_ok && !push_ok)
      count_d = count_q - 3'h1;
  end

  // occupancy register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      count_q <= 3'h0;
    else
      count_q <= count_d;
  end

  assign port.count = count_q;
endmodule

// ==== verilog/smartcard_irq_status_logic.sv ====
// Local design decision: strobed register access.
`timescale 1ns/10ps
`include "irq_map.svh"
module smartcard_irq_status_logic
  import irq_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic [31:0]     rdata,
  // interrupt to the processor
  output logic            irq,
  // answer-to-reset convention byte
  input  wire logic       ts_valid,
  input  wire logic [7:0] ts_byte,
  // sequencer handshake
  input  wire logic       act_done,
  input  wire logic       deact_done,
  input  wire logic       warm_done,
  output logic            activation_start,
  output logic            deactivation_start,
  output logic            warm_reset_start,
  // receive side events
  input  wire logic       rx_byte_in,
  input  wire logic [7:0] rx_head_data,
  input  wire logic       rx_timeout_evt,
  input  wire logic       rx_break_evt,
  input  wire logic       rx_frame_evt,
  input  wire logic       rx_parity_evt,
  input  wire logic       rx_retry_limit_evt,
  input  wire logic       rx_busy,
  output logic            rx_pop,
  output logic            rx_retry_enable,
  output logic            rx_block_guard_enable,
  // transmit side events
  input  wire logic       tx_load,
  input  wire logic       tx_retry_evt,
  input  wire logic       tx_retry_limit_evt,
  input  wire logic       tx_busy,
  output logic            tx_push,
  output logic [7:0]      tx_data,
  // card detect, guard time and timers
  input  wire logic       card_inserted,
  input  wire logic       card_removed,
  input  wire logic       block_guard_evt,
  input  wire logic       timer_zero_evt,
  input  wire logic       timer_one_evt,
  input  wire logic       timer_two_evt
);

  // true when a convention byte is neither allowed value
  function automatic logic bad_convention(input logic [7:0] b);
    bad_convention = (b != `TS_DIRECT) && (b != `TS_INVERSE);
  endfunction

  // trigger level code to byte count; code 3 saturates at three
  function automatic occ_t trigger_count(input logic [1:0] lev);
    case (lev)
      2'h0:    trigger_count = 3'h1;
      2'h1:    trigger_count = 3'h2;
      default: trigger_count = 3'h3;
    endcase
  endfunction

  flag_if isr_f ();          // sticky interrupt status flags
  flag_if trsr_f ();         // sticky transfer status flags
  occ_if  rx_occ ();         // receive buffer occupancy
  occ_if  tx_occ ();         // transmit buffer occupancy

  word_t       ier_q;        // interrupt enables
  logic [7:0]  ctrl_q;       // sequence starts and rx config
  logic        rto_q;        // receive timeout flag
  logic        tx_empty_q;   // transmit buffer empty flag
  logic        tx_act_q;     // transmit in progress
  logic        rx_act_q;     // receive in progress
  logic        irq_q;        // registered interrupt
  word_t       rdata_q;      // read data, one cycle after strobe
  logic        tx_push_q;    // byte handed to holding buffer
  logic [7:0]  tx_data_q;    // byte written by software
  logic        rx_pop_q;     // byte taken from receive buffer
  word_t       isr_val;      // interrupt status as read
  word_t       trsr_val;     // transfer status as read
  logic        terr;         // any transfer error
  logic        rda;          // receive level reached
  logic        seq_done;     // any sequence completed
  logic        wr_data;      // holding buffer write
  logic        rd_data;      // receive buffer read

  // strobe decode
  assign wr_data = wr_en && (addr == `OFS_DATA);
  assign rd_data = rd_en && (addr == `OFS_DATA);
  assign seq_done = act_done || deact_done || warm_done;

  // buffer trackers
  assign rx_occ.push = rx_byte_in;
  assign rx_occ.pop  = rd_data;
  assign tx_occ.push = wr_data;
  assign tx_occ.pop  = tx_load;

  sticky_flags u_isr_flags (
    .clk    (clk),
    .resetn (resetn),
    .bus    (isr_f.bank)
  );

  sticky_flags u_trsr_flags (
    .clk    (clk),
    .resetn (resetn),
    .bus    (trsr_f.bank)
  );

  occupancy_counter u_rx_count (
    .clk    (clk),
    .resetn (resetn),
    .port   (rx_occ.cnt)
  );

  occupancy_counter u_tx_count (
    .clk    (clk),
    .resetn (resetn),
    .port   (tx_occ.cnt)
  );

  // interrupt status set and clear terms
  always_comb
  begin
    isr_f.set = 32'h00000000;
    isr_f.set[`ISR_CONV] = ts_valid && bad_convention(ts_byte);
    isr_f.set[`ISR_INIT] = seq_done;
    isr_f.set[`ISR_CD]   = card_inserted || card_removed;
    isr_f.set[`ISR_BGT]  = block_guard_evt && ctrl_q[`CT_BGT_EN];
    isr_f.set[`ISR_TMR2] = timer_two_evt;
    isr_f.set[`ISR_TMR1] = timer_one_evt;
    isr_f.set[`ISR_TMR0] = timer_zero_evt;
    isr_f.clr = (wr_en && (addr == `OFS_ISR)) ? (wdata & `ISR_W1C_MASK) : 32'h00000000;
  end

  // transfer status set and clear terms
  always_comb
  begin
    trsr_f.set = 32'h00000000;
    trsr_f.set[`TR_TX_LIMIT]  = tx_retry_limit_evt;
    trsr_f.set[`TR_TX_RETRY]  = tx_retry_evt;
    trsr_f.set[`TR_RX_LIMIT]  = rx_retry_limit_evt;
    trsr_f.set[`TR_CD_INS]    = card_inserted;
    trsr_f.set[`TR_CD_REM]    = card_removed;
    trsr_f.set[`TR_TX_OVER]   = tx_occ.over;
    // retry mode suppresses the receive break, frame and parity flags
    trsr_f.set[`TR_RX_BREAK]  = rx_break_evt && !ctrl_q[`CT_RETRY_EN];
    trsr_f.set[`TR_RX_FRAME]  = rx_frame_evt && !ctrl_q[`CT_RETRY_EN];
    trsr_f.set[`TR_RX_PARITY] = rx_parity_evt && !ctrl_q[`CT_RETRY_EN];
    // overflow on byte into full buffer
    trsr_f.set[`TR_RX_OVER]   = rx_occ.over;
    trsr_f.clr = (wr_en && (addr == `OFS_TRSR)) ? (wdata & `TR_W1C_MASK) : 32'h00000000;
  end

  // status words as software sees them
  always_comb
  begin
    // error summary clears only when every source is cleared
    terr = |(trsr_f.q & `TR_ERR_MASK);
    // level compare, drops as reads lower the count
    rda  = rx_occ.count >= trigger_count(ctrl_q[`CT_LEV_HI:`CT_LEV_LO]);
    isr_val = isr_f.q & `ISR_W1C_MASK;
    isr_val[`ISR_RTO]  = rto_q;
    isr_val[`ISR_TERR] = terr;
    isr_val[`ISR_TBE]  = tx_empty_q;
    isr_val[`ISR_RDA]  = rda;
    trsr_val = trsr_f.q & `TR_W1C_MASK;
    trsr_val[`TR_TX_ACT] = tx_act_q;
    // pointer field; four shows as zero, full bit disambiguates
    trsr_val[`TR_TX_PTR_HI:`TR_TX_PTR_LO] = tx_occ.count[1:0];
    trsr_val[`TR_RX_ACT] = rx_act_q;
    trsr_val[`TR_RX_PTR_HI:`TR_RX_PTR_LO] = rx_occ.count[1:0];
    trsr_val[`TR_TX_FULL]  = tx_occ.count == `BUF_DEPTH;
    trsr_val[`TR_TX_EMPTY] = tx_empty_q;
    trsr_val[`TR_RX_FULL]  = rx_occ.count == `BUF_DEPTH;
    trsr_val[`TR_RX_EMPTY] = rx_occ.count == 3'h0;
  end

  // enable register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ier_q <= 32'h00000000;
    else if (wr_en && (addr == `OFS_IER))
      ier_q <= wdata & `IER_MASK;
  end

  // control: starts set by write, cleared by their own completion
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_q <= 8'h00;
    else
    begin
      if (wr_en && (addr == `OFS_CTRL))
      begin
        // config bits take the write, start bits only set
        ctrl_q <= (wdata[7:0] & `CT_CFG_MASK) | (ctrl_q & ~`CT_CFG_MASK) |
                  (wdata[7:0] & ~`CT_CFG_MASK & 8'(`CT_MASK));
      end
      // completion wins over a racing start write
      if (act_done)
        ctrl_q[`CT_ACT] <= 1'b0;
      if (deact_done)
        ctrl_q[`CT_DEACT] <= 1'b0;
      if (warm_done)
        ctrl_q[`CT_WARM] <= 1'b0;
    end
  end

  // timeout flag ignores writes, ends when last byte is read
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rto_q <= 1'b0;
    else if (rx_timeout_evt)
      rto_q <= 1'b1;
    else if (rx_occ.drain)
      rto_q <= 1'b0;
  end

  // empty flag: set by last load, cleared by a buffer write
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tx_empty_q <= 1'b1;
    else if (tx_occ.drain)
      tx_empty_q <= 1'b1;
    else if (wr_data)
      tx_empty_q <= 1'b0;
  end

  // activity levels from the serial engine
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_act_q <= 1'b0;
      rx_act_q <= 1'b0;
    end
    else
    begin
      tx_act_q <= tx_busy;
      rx_act_q <= rx_busy;
    end
  end

  // one interrupt line, OR of enabled status bits
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(isr_val & ier_q);
  end

  // read mux; unmapped addresses read zero
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 32'h00000000;
    else if (rd_en)
    begin
      case (addr)
        `OFS_DATA: rdata_q <= {24'h000000, rx_head_data};
        `OFS_IER:  rdata_q <= ier_q;
        `OFS_ISR:  rdata_q <= isr_val;
        `OFS_TRSR: rdata_q <= trsr_val;
        `OFS_CTRL: rdata_q <= {24'h000000, ctrl_q} & `CT_MASK;
        default:   rdata_q <= 32'h00000000;
      endcase
    end
  end

  // data strobes toward the buffers; a full buffer drops the byte
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_push_q <= 1'b0;
      tx_data_q <= 8'h00;
      rx_pop_q  <= 1'b0;
    end
    else
    begin
      tx_push_q <= wr_data && !tx_occ.over;
      if (wr_data)
        tx_data_q <= wdata[7:0];
      rx_pop_q  <= rd_data && (rx_occ.count != 3'h0);
    end
  end

  assign rdata                 = rdata_q;
  assign irq                   = irq_q;
  assign activation_start      = ctrl_q[`CT_ACT];
  assign deactivation_start    = ctrl_q[`CT_DEACT];
  assign warm_reset_start      = ctrl_q[`CT_WARM];
  assign rx_retry_enable       = ctrl_q[`CT_RETRY_EN];
  assign rx_block_guard_enable = ctrl_q[`CT_BGT_EN];
  assign tx_push               = tx_push_q;
  assign tx_data               = tx_data_q;
  assign rx_pop                = rx_pop_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  irq_gate_a: assert property (irq == $past(|(isr_val & ier_q)))
    else $error("interrupt does not match enabled status");
  conv_error_a: assert property (ts_valid && bad_convention(ts_byte) |=> isr_val[`ISR_CONV])
    else $error("bad convention byte not flagged");
  init_hold_a: assert property (isr_val[`ISR_INIT] && !(wr_en && addr == `OFS_ISR &&
    wdata[`ISR_INIT]) |=> isr_val[`ISR_INIT])
    else $error("init end flag cleared without write one");
  timeout_hold_a: assert property (rto_q && !rx_occ.drain |=> rto_q)
    else $error("timeout flag cleared early");
  seq_end_a: assert property (act_done |=> isr_val[`ISR_INIT] && !activation_start)
    else $error("activation end not handled");
  card_detect_a: assert property (card_removed |=> isr_val[`ISR_CD] && trsr_val[`TR_CD_REM])
    else $error("card removal not flagged");
  tx_empty_clr_a: assert property (wr_data && !tx_occ.drain |=> !tx_empty_q ##1 (!tx_empty_q
    || $past(tx_occ.drain)))
    else $error("tx empty flag not cleared by write");
  tx_ptr_up_a: assert property (wr_data && !tx_load && tx_occ.count < `BUF_DEPTH
    |=> tx_occ.count == $past(tx_occ.count) + 3'h1)
    else $error("tx pointer did not advance");
  parity_gate_a: assert property (ctrl_q[`CT_RETRY_EN] && !trsr_val[`TR_RX_PARITY]
    |=> !trsr_val[`TR_RX_PARITY])
    else $error("parity flag set in retry mode");
  rx_over_a: assert property (rx_byte_in && rx_occ.count == `BUF_DEPTH
    |=> trsr_val[`TR_RX_OVER] && isr_val[`ISR_TERR])
    else $error("rx overflow not flagged");
  tx_retry_a: assert property (tx_retry_evt |=> trsr_val[`TR_TX_RETRY])
    else $error("tx retry not flagged");

  irq_seen_c: cover property (timer_zero_evt && ier_q[`ISR_TMR0] ##2 irq);
  rx_fill_c:  cover property (rx_occ.count == `BUF_DEPTH ##[1:20] rx_occ.drain);
  tx_drain_c: cover property (tx_occ.count == 3'h2 ##[1:20] tx_occ.drain);
  warm_c:     cover property (warm_reset_start ##[1:50] warm_done);
endmodule

// ==== test/sc_partner.sv ====
`timescale 1ns/10ps
module sc_partner
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // transmit side
  input  wire logic       tx_push,
  input  wire logic [7:0] tx_data,
  input  wire logic       drain,
  output logic            tx_load,
  output logic            tx_busy,
  // receive side
  input  wire logic       rx_pop,
  input  wire logic       rx_hold,
  output logic            rx_byte_in,
  output logic            rx_busy,
  output logic [7:0]      rx_head_data
);
  logic [7:0] txq[$];  // bytes waiting to shift
  logic [7:0] got[$];  // bytes sent to the card
  logic [7:0] rxq[$];  // mirror of the rx buffer
  logic [7:0] last_b;  // last byte popped
  logic [7:0] rx_nb;   // byte being received
  logic       sending; // rx frame in flight
  int         gap;     // shift time left
  // busy while a frame arrives or the bench holds it
  assign rx_busy = sending | rx_hold;
  initial
  begin
    last_b = 8'h00;
    rx_nb = 8'h00;
    sending = 1'h0;
    rx_byte_in = 1'h0;
    rx_head_data = 8'hFF;
  end
  // one byte every four cycles, only while draining
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_load <= 1'h0;
      tx_busy <= 1'h0;
      gap = 0;
    end
    else
    begin
      tx_load <= 1'h0;
      if (tx_push)
        txq.push_back(tx_data);
      if (gap != 0)
        gap--;
      else if (drain && txq.size() != 0)
      begin
        tx_load <= 1'h1;
        got.push_back(txq.pop_front());
        gap = 3;
      end
      // queued bytes with the shifter stalled are not a transfer
      tx_busy <= (gap != 0) || (drain && txq.size() != 0);
    end
  end
  // a byte into a full buffer is lost, as on the wire
  always @(posedge clk)
  begin
    if (rx_pop && rxq.size() != 0)
      last_b = rxq.pop_front();
    if (rx_byte_in && rxq.size() < 4)
      rxq.push_back(rx_nb);
    // an empty buffer shows no stale byte
    rx_head_data <= (rxq.size() != 0) ? rxq[0] : ~last_b;
  end
  // busy two cycles, then the byte lands
  task rx_send(input logic [7:0] b);
    @(posedge clk);
    sending <= 1'h1;
    repeat (2) @(posedge clk);
    rx_nb <= b;
    rx_byte_in <= 1'h1;
    @(posedge clk);
    rx_byte_in <= 1'h0;
    sending <= 1'h0;
  endtask
endmodule

// ==== test/smartcard_irq_status_logic_tb.sv ====
`timescale 1ns/10ps
`include "irq_map.svh"
module smartcard_irq_status_logic_tb;
  import irq_pkg::*;
  // register port and partner control
  logic        clk, resetn, wr_en, rd_en, drain, rx_hold;
  logic [7:0]  addr, ts_byte, tx_data, rx_head;
  word_t       wdata, rdata, v;
  logic [16:0] ev; // one event pulse per bit
  logic        irq, act_s, dct_s, wrm_s, rx_pop, rty_en, bgt_en;
  logic        tx_push, tx_load, tx_busy, rx_byte_in, rx_busy;
  int          fails, cmp_count, cyc;

  smartcard_irq_status_logic u_smartcard_irq_status_logic (.clk, .resetn, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .irq, .ts_valid(ev[16]), .ts_byte, .act_done(ev[6]),
    .deact_done(ev[7]), .warm_done(ev[8]), .activation_start(act_s),
    .deactivation_start(dct_s), .warm_reset_start(wrm_s), .rx_byte_in,
    .rx_head_data(rx_head), .rx_timeout_evt(ev[9]), .rx_break_evt(ev[10]),
    .rx_frame_evt(ev[11]), .rx_parity_evt(ev[12]), .rx_retry_limit_evt(ev[13]), .rx_busy,
    .rx_pop, .rx_retry_enable(rty_en), .rx_block_guard_enable(bgt_en), .tx_load,
    .tx_retry_evt(ev[14]), .tx_retry_limit_evt(ev[15]), .tx_busy, .tx_push, .tx_data,
    .card_inserted(ev[4]), .card_removed(ev[5]), .block_guard_evt(ev[3]),
    .timer_zero_evt(ev[0]), .timer_one_evt(ev[1]), .timer_two_evt(ev[2]));
  sc_partner u_sc_partner (.clk, .resetn, .tx_push, .tx_data, .drain, .tx_load, .tx_busy,
    .rx_pop, .rx_hold, .rx_byte_in, .rx_busy, .rx_head_data(rx_head));

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      give_verdict();
    end
  end
  task automatic chk(input word_t got, input word_t exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
    #1;
  endtask
  // read data stands one cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1;
    v = rdata;
  endtask
  task automatic pulse(input int i, input logic [7:0] b);
    @(posedge clk);
    ev <= 17'h1 << i;
    ts_byte <= b;
    @(posedge clk);
    ev <= 17'h0;
    #1;
  endtask
  task automatic t_reset();
    rd(`OFS_ISR);
    chk(v, `ISR_RESET);
    rd(`OFS_TRSR);
    chk(v, `TR_RESET);
    rd(8'h40);
    chk(v, 32'h0);
    wr(`OFS_IER, 32'hFFFFFFFF);
    rd(`OFS_IER);
    chk(v, `IER_MASK);
    chk(word_t'(irq), 32'h1);
    wr(`OFS_IER, 32'h0);
  endtask
  // timers, guard, card detect and the three sequences
  task automatic t_flags();
    int         ix[10] = '{0, 1, 2, 3, 3, 4, 5, 6, 7, 8};
    int         bt[10] = '{3, 4, 5, 6, 6, 7, 7, 8, 8, 8};
    logic [4:0] cv[10] = '{5'h0, 5'h0, 5'h0, 5'h0, 5'h10, 5'h0, 5'h0, 5'h1, 5'h2, 5'h4};
    word_t      m;
    word_t      e;
    for (int n = 0; n < 10; n++)
    begin
      m = 32'h1 << bt[n];
      e = (n == 3) ? 32'h0 : m;
      wr(`OFS_CTRL, word_t'(cv[n]));
      chk(word_t'({bgt_en, wrm_s, dct_s, act_s}), word_t'({cv[n][4], cv[n][2:0]}));
      pulse(ix[n], 8'h00);
      chk(word_t'({wrm_s, dct_s, act_s}), 32'h0);
      rd(`OFS_ISR);
      chk(v, `ISR_RESET | e);
      chk(word_t'(irq), 32'h0);
      wr(`OFS_IER, m);
      rd(`OFS_ISR);
      chk(word_t'(irq), e >> bt[n]);
      wr(`OFS_ISR, ~m);
      rd(`OFS_ISR);
      chk(v, `ISR_RESET | e);
      wr(`OFS_ISR, m);
      rd(`OFS_ISR);
      chk(v, `ISR_RESET);
      wr(`OFS_IER, 32'h0);
    end
    wr(`OFS_TRSR, 32'hFFFFFFFF);
  endtask
  task automatic t_conv();
    logic [7:0] tv[3] = '{`TS_DIRECT, `TS_INVERSE, 8'h5A};
    wr(`OFS_IER, 32'h400);
    for (int k = 0; k < 3; k++)
    begin
      pulse(16, tv[k]);
      rd(`OFS_ISR);
      chk(v, (k == 2) ? 32'h402 : 32'h2);
      chk(word_t'(irq), (k == 2) ? 32'h1 : 32'h0);
      wr(`OFS_ISR, 32'h400);
    end
    wr(`OFS_IER, 32'h0);
  endtask
  task automatic t_errors();
    int    ix[6] = '{10, 11, 12, 13, 15, 14};
    int    bt[6] = '{6, 5, 4, 22, 30, 29};
    word_t m;
    wr(`OFS_IER, 32'h4);
    for (int k = 0; k < 6; k++)
    begin
      m = 32'h1 << bt[k];
      pulse(ix[k], 8'h00);
      rd(`OFS_TRSR);
      chk(v & m, m);
      rd(`OFS_ISR);
      chk(v & 32'h4, (k < 5) ? 32'h4 : 32'h0);
      chk(word_t'(irq), (k < 5) ? 32'h1 : 32'h0);
      wr(`OFS_TRSR, m);
      rd(`OFS_TRSR);
      chk(v & m, 32'h0);
    end
    // two sources, cleared one at a time
    pulse(10, 8'h00);
    pulse(11, 8'h00);
    wr(`OFS_TRSR, 32'h40);
    rd(`OFS_ISR);
    chk(v & 32'h4, 32'h4);
    wr(`OFS_TRSR, 32'h20);
    rd(`OFS_ISR);
    chk(v & 32'h4, 32'h0);
    wr(`OFS_CTRL, 32'h8);
    chk(word_t'(rty_en), 32'h1);
    pulse(12, 8'h00);
    rd(`OFS_TRSR);
    chk(v & 32'h10, 32'h0);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_IER, 32'h0);
  endtask
  // fill the holding buffer past full with the shifter stalled
  task automatic t_tx();
    int c;
    for (int k = 0; k < 5; k++)
    begin
      wr(`OFS_DATA, 32'hA0 + k);
      c = (k < 4) ? k + 1 : 4;
      rd(`OFS_TRSR);
      chk(v, 32'h2 | (word_t'(c % 4) << 24) | ((c == 4) ? 32'h400 : 32'h0)
        | ((k == 4) ? 32'h100 : 32'h0));
      rd(`OFS_ISR);
      chk(v, (k == 4) ? 32'h4 : 32'h0);
    end
    @(posedge clk);
    drain <= 1'h1;
    repeat (6) @(posedge clk);
    rd(`OFS_TRSR);
    chk(v & 32'h80000000, 32'h80000000);
    for (int i = 0; i < 100 && u_sc_partner.got.size() < 4; i++)
      @(posedge clk);
    repeat (8) @(posedge clk);
    rd(`OFS_TRSR);
    chk(v, 32'h302);
    rd(`OFS_ISR);
    chk(v, 32'h6);
    for (int i = 0; i < 4; i++)
      chk(word_t'(u_sc_partner.got[i]), 32'hA0 + i);
    wr(`OFS_TRSR, 32'h100);
    drain <= 1'h0;
  endtask
  // two byte trigger level, overflow, then drain by reads
  task automatic t_rx();
    wr(`OFS_CTRL, 32'h40);
    wr(`OFS_IER, 32'h201);
    for (int k = 0; k < 5; k++)
    begin
      u_sc_partner.rx_send(8'(8'h50 + k));
      rd(`OFS_ISR);
      // tx empty still stands from the drained holding buffer
      chk(v, 32'h2 | ((k == 4) ? 32'h5 : (k > 0) ? 32'h1 : 32'h0));
    end
    rd(`OFS_TRSR);
    chk(v & 32'h5, 32'h5);
    rx_hold <= 1'h1;
    rd(`OFS_TRSR);
    chk(v & 32'h800000, 32'h800000);
    rx_hold <= 1'h0;
    pulse(9, 8'h00);
    wr(`OFS_ISR, 32'h200);
    for (int k = 0; k < 4; k++)
    begin
      rd(`OFS_DATA);
      chk(v & 32'hFF, 32'h50 + k);
      rd(`OFS_ISR);
      chk(v & 32'h201, ((k < 3) ? 32'h200 : 32'h0) | ((k < 2) ? 32'h1 : 32'h0));
      chk(word_t'(irq), (k < 3) ? 32'h1 : 32'h0);
    end
    wr(`OFS_TRSR, 32'hFFFFFFFF);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_IER, 32'h0);
    rd(`OFS_TRSR);
    chk(v, `TR_RESET);
  endtask
  initial
  begin
    resetn = 1'h0;
    {wr_en, rd_en, drain, rx_hold} = 4'h0;
    {addr, ts_byte, wdata, ev} = '0;
    {fails, cmp_count, cyc} = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    t_reset();
    t_flags();
    t_conv();
    t_errors();
    t_tx();
    t_rx();
    give_verdict();
  end
endmodule
